// File: rtl/pmc_phy.sv
// data-side and management control logic of a 10/100 transceiver
// assumes a line decoder on mii_clk and a clause 22 management host
`include "pmc_params.svh"
module pmc_phy #(
  parameter int JAB_CYCLES = `PMC_JAB_MS * (`PMC_CORE_HZ / 1000),
  parameter int UNJAB_CYCLES = `PMC_UNJAB_MS * (`PMC_CORE_HZ / 1000),
  parameter int CNT_W = 24
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic mii_clk,
  input wire pmc_pkg::pmc_mii_tx_type mii_tx,
  output pmc_pkg::pmc_mii_rx_type mii_rx,
  output logic mii_col,
  input wire pmc_pkg::pmc_line_rx_type line_rx,
  input wire logic line_lock,
  output pmc_pkg::pmc_line_tx_type line_tx,
  output logic rx_clk_from_line,
  input wire logic link_up,
  input wire logic nlp_seen,
  input wire logic idle100_seen,
  input wire logic lcw_valid,
  input wire logic [15:0] lcw_word,
  output logic flp_send,
  output logic [15:0] flp_word,
  output logic mode_100,
  output logic mode_full,
  input wire logic [4:0] address_straps,
  input wire logic strap_an_en,
  input wire logic strap_speed100,
  input wire logic strap_full,
  input wire logic strap_reduced,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  output logic mgmt_irq_out
);
  if (CNT_W > 31 || JAB_CYCLES < 1 || UNJAB_CYCLES < 1 ||
      JAB_CYCLES >= (1 << CNT_W) || UNJAB_CYCLES >= (1 << CNT_W))
  begin : g_chk
    $error("pmc_phy: timing counts do not fit the counter");
  end

  function automatic logic [1:0] pmc_prio(input logic [15:0] abil);
    logic [1:0] m;
    m = 2'b00;
    if ((abil & `PMC_ABIL_100FD) != 16'h0000) m = 2'b11;
    else if ((abil & `PMC_ABIL_100HD) != 16'h0000) m = 2'b10;
    else if ((abil & `PMC_ABIL_10FD) != 16'h0000) m = 2'b01;
    return m;
  endfunction : pmc_prio

  // --------------------------------------------------------------------
  // core-domain synchronisers
  // --------------------------------------------------------------------
  logic [14:0] as_s1, as_s2;
  logic tx_busy_mii;
  logic mdc_s, mdc_prev, mdio_s, link_s, link_prev, nlp_s, idle_s, busy_s;
  logic mdc_rise, link_rise, link_fall;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      as_s1 <= 15'h0000;
      as_s2 <= 15'h0000;
      mdc_prev <= 1'b0;
      link_prev <= 1'b0;
    end
    else if (ce)
    begin
      as_s1 <= {address_straps, strap_an_en, strap_speed100, strap_full,
                strap_reduced, mdc, mdio_in, link_up, nlp_seen,
                idle100_seen, tx_busy_mii};
      as_s2 <= as_s1;
      mdc_prev <= mdc_s;
      link_prev <= link_s;
    end
  end
  assign {mdc_s, mdio_s, link_s, nlp_s, idle_s, busy_s} = as_s2[5:0];
  assign mdc_rise = mdc_s & ~mdc_prev;
  assign link_rise = link_s & ~link_prev;
  assign link_fall = ~link_s & link_prev;

  // --------------------------------------------------------------------
  // straps and management registers
  // --------------------------------------------------------------------
  logic [1:0] strap_cnt;
  logic strap_taken, strap_load;
  logic [4:0] phy_addr;
  logic ctrl_an_en, ctrl_spd, ctrl_dup, pol_high, reduced_mode;
  logic [15:0] adv;
  logic [7:0] int_en;
  logic wr_stb, an_restart;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;
  assign strap_load = (strap_cnt == `PMC_STRAP_WAIT) && !strap_taken;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt <= 2'h0;
      strap_taken <= 1'b0;
      phy_addr <= 5'h00;
      ctrl_an_en <= 1'b0;
      ctrl_spd <= 1'b0;
      ctrl_dup <= 1'b0;
      reduced_mode <= 1'b0;
      pol_high <= 1'b0;
      adv <= `PMC_ADV_RESET;
      int_en <= 8'h00;
      an_restart <= 1'b0;
    end
    else if (ce)
    begin
      an_restart <= 1'b0;
      if (strap_cnt != `PMC_STRAP_WAIT)
        strap_cnt <= strap_cnt + 2'h1;
      if (strap_load)
      begin
        // strap levels caught after release, through the synchroniser
        strap_taken <= 1'b1;
        phy_addr <= as_s2[14:10];
        ctrl_an_en <= as_s2[9];
        ctrl_spd <= as_s2[8];
        ctrl_dup <= as_s2[7];
        reduced_mode <= as_s2[6];
        adv <= `PMC_ADV_RESET | (as_s2[8] ?
               (as_s2[7] ? 16'h01E0 : 16'h00A0) : 16'h0060);
      end
      else if (wr_stb)
      begin
        unique case (wr_addr)
          `PMC_REG_CTRL:
          begin
            ctrl_spd <= wr_data[`PMC_CTRL_SPD];
            ctrl_an_en <= wr_data[`PMC_CTRL_ANEN];
            ctrl_dup <= wr_data[`PMC_CTRL_DUP];
            an_restart <= wr_data[`PMC_CTRL_RESTART];
          end
          `PMC_REG_ADV: adv <= wr_data;
          `PMC_REG_INT: int_en <= wr_data[15:8];
          `PMC_REG_PCTL: pol_high <= wr_data[`PMC_PCTL_POL];
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // auto-negotiation and parallel detection
  // --------------------------------------------------------------------
  pmc_pkg::pmc_an_type an_state;
  logic [15:0] partner, last_lcw, lcw_m;
  logic [1:0] rep_cnt, an_mode;
  logic page_evt;
  assign lcw_m = lcw_word & `PMC_LCW_ACK_MASK;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      an_state <= pmc_pkg::AN_OFF;
      partner <= 16'h0000;
      last_lcw <= 16'h0000;
      rep_cnt <= 2'h0;
      an_mode <= 2'b00;
      page_evt <= 1'b0;
    end
    else if (ce)
    begin
      page_evt <= 1'b0;
      if (!ctrl_an_en)
        an_state <= pmc_pkg::AN_OFF;
      else if (strap_load || link_fall || an_restart ||
               an_state == pmc_pkg::AN_OFF)
      begin
        an_state <= pmc_pkg::AN_SEND;
        rep_cnt <= 2'h0;
      end
      else if (an_state != pmc_pkg::AN_DONE)
      begin
        if (idle_s)
        begin
          an_mode <= pmc_prio(`PMC_ABIL_100HD);
          an_state <= pmc_pkg::AN_DONE;
        end
        else if (nlp_s)
        begin
          an_mode <= pmc_prio(`PMC_ABIL_10HD);
          an_state <= pmc_pkg::AN_DONE;
        end
        else if (lcw_valid)
        begin
          last_lcw <= lcw_m;
          if (lcw_m != last_lcw || rep_cnt == 2'h0)
            rep_cnt <= 2'h1;
          else if (rep_cnt + 2'h1 == `PMC_LCW_REPEAT)
          begin
            rep_cnt <= 2'h0;
            if (an_state == pmc_pkg::AN_SEND)
            begin
              partner <= lcw_word;
              page_evt <= 1'b1;
              an_state <= pmc_pkg::AN_ACK;
            end
            else
            begin
              an_mode <= pmc_prio(adv & partner);
              an_state <= pmc_pkg::AN_DONE;
            end
          end
          else
            rep_cnt <= rep_cnt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_100 <= 1'b0;
      mode_full <= 1'b0;
      flp_send <= 1'b0;
      flp_word <= 16'h0000;
    end
    else if (ce)
    begin
      mode_100 <= ctrl_an_en ? an_mode[1] : ctrl_spd;
      mode_full <= ctrl_an_en ? an_mode[0] : ctrl_dup;
      flp_send <= an_state == pmc_pkg::AN_SEND ||
                  an_state == pmc_pkg::AN_ACK;
      flp_word <= adv;
    end
  end

  // --------------------------------------------------------------------
  // jabber timing, kept in the core domain for a known rate
  // --------------------------------------------------------------------
  logic jabber;
  logic [CNT_W-1:0] jab_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jabber <= 1'b0;
      jab_cnt <= '0;
    end
    else if (ce)
    begin
      if (!jabber)
      begin
        if (!busy_s || mode_100)
          jab_cnt <= '0;
        else if (jab_cnt == CNT_W'(JAB_CYCLES))
        begin
          jabber <= 1'b1;
          jab_cnt <= '0;
        end
        else
          jab_cnt <= jab_cnt + 1'b1;
      end
      else if (busy_s)
        jab_cnt <= '0;
      else if (jab_cnt == CNT_W'(UNJAB_CYCLES))
      begin
        jabber <= 1'b0;
        jab_cnt <= '0;
      end
      else
        jab_cnt <= jab_cnt + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // interrupt flags and output
  // --------------------------------------------------------------------
  logic [7:0] int_flags, int_set, int_clr;
  logic rd_clr;
  always_comb
  begin
    int_set = 8'h00;
    int_set[`PMC_INT_LINK_UP] = link_rise;
    int_set[`PMC_INT_LINK_DOWN] = link_fall;
    int_set[`PMC_INT_PAGE_RX] = page_evt;
    int_clr = rd_clr ? 8'hFF : 8'h00;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_flags <= 8'h00;
      mgmt_irq_out <= 1'b1;
    end
    else if (ce)
    begin
      // a new event wins over the read that clears
      int_flags <= (int_flags & ~int_clr) | int_set;
      mgmt_irq_out <= pol_high ? |(int_en & int_flags)
                               : ~|(int_en & int_flags);
    end
  end

  // --------------------------------------------------------------------
  // management frame engine
  // --------------------------------------------------------------------
  pmc_pkg::pmc_md_type md_state;
  logic [5:0] ones;
  logic [3:0] hdr_cnt;
  logic [4:0] dcnt;
  logic [11:0] hdr;
  logic [12:0] hdr_full;
  logic [15:0] shreg, rd_mux;
  logic md_rd;
  assign hdr_full = {hdr, mdio_s};
  always_comb
  begin
    unique case (hdr_full[4:0])
      `PMC_REG_CTRL: rd_mux = 16'h0000 | ({15'h0000, ctrl_spd}
                     << `PMC_CTRL_SPD) | ({15'h0000, ctrl_an_en}
                     << `PMC_CTRL_ANEN) | ({15'h0000, ctrl_dup}
                     << `PMC_CTRL_DUP);
      `PMC_REG_ADV: rd_mux = adv;
      `PMC_REG_LPA: rd_mux = partner;
      `PMC_REG_INT: rd_mux = {int_en, int_flags};
      `PMC_REG_PCTL: rd_mux = {15'h0000, pol_high} << `PMC_PCTL_POL;
      default: rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      md_state <= pmc_pkg::MD_IDLE;
      ones <= 6'h00;
      hdr_cnt <= 4'h0;
      dcnt <= 5'h00;
      hdr <= 12'h000;
      shreg <= 16'h0000;
      md_rd <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 16'h0000;
      rd_clr <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      if (mdc_rise)
      begin
        unique case (md_state)
          pmc_pkg::MD_IDLE:
          begin
            if (mdio_s)
              ones <= (ones == `PMC_MDIO_PRE_ONES) ? ones : ones + 6'h01;
            else
            begin
              if (ones == `PMC_MDIO_PRE_ONES)
                md_state <= pmc_pkg::MD_HDR;
              ones <= 6'h00;
              hdr_cnt <= 4'h0;
            end
          end
          pmc_pkg::MD_HDR:
          begin
            hdr <= hdr_full[11:0];
            hdr_cnt <= hdr_cnt + 4'h1;
            if (hdr_cnt == `PMC_MDIO_HDR_LAST)
            begin
              dcnt <= 5'h00;
              wr_addr <= hdr_full[4:0];
              md_rd <= hdr_full[11:10] == 2'b10;
              shreg <= rd_mux;
              if (hdr_full[12] && hdr_full[9:5] == phy_addr &&
                  (hdr_full[11:10] == 2'b10 || hdr_full[11:10] == 2'b01))
              begin
                md_state <= pmc_pkg::MD_DATA;
                rd_clr <= hdr_full[11:10] == 2'b10 &&
                          hdr_full[4:0] == `PMC_REG_INT;
              end
              else
                md_state <= pmc_pkg::MD_IDLE;
            end
          end
          pmc_pkg::MD_DATA:
          begin
            dcnt <= dcnt + 5'h01;
            if (md_rd)
            begin
              if (dcnt == 5'h00)
              begin
                mdio_oe_n <= 1'b0;
                mdio_out <= 1'b0;
              end
              else if (dcnt != `PMC_MDIO_DATA_LAST)
              begin
                mdio_out <= shreg[15];
                shreg <= {shreg[14:0], 1'b0};
              end
            end
            else if (dcnt >= 5'h02)
              wr_data <= {wr_data[14:0], mdio_s};
            if (dcnt == `PMC_MDIO_DATA_LAST)
            begin
              mdio_oe_n <= 1'b1;
              mdio_out <= 1'b1;
              wr_stb <= !md_rd;
              md_state <= pmc_pkg::MD_IDLE;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // link-clock side: levels crossing in, transmit and receive pins
  // --------------------------------------------------------------------
  logic [6:0] ms1, ms2;
  logic m100, mfull, mjab, mred, man, mlink, mce, jab10;
  logic [3:0] sqe_cnt;
  pmc_pkg::pmc_mii_tx_type tx_q;
  always_ff @(posedge mii_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms1 <= 7'h00;
      ms2 <= 7'h00;
    end
    else
    begin
      ms1 <= {mode_100, mode_full, jabber, reduced_mode, ctrl_an_en,
              link_s, ce};
      ms2 <= ms1;
    end
  end
  assign {m100, mfull, mjab, mred, man, mlink, mce} = ms2;
  assign jab10 = mjab & ~m100;
  assign tx_busy_mii = tx_q.en;

  always_ff @(posedge mii_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_q <= '0;
      line_tx <= '0;
      sqe_cnt <= 4'h0;
    end
    else if (mce)
    begin
      tx_q <= mii_tx;
      line_tx.active <= mii_tx.en && !jab10;
      line_tx.halt <= mii_tx.en && mii_tx.er;
      line_tx.d <= mii_tx.d;
      if (tx_q.en && !mii_tx.en && !m100 && !mjab)
        sqe_cnt <= `PMC_SQE_CYCLES;
      else if (sqe_cnt != 4'h0)
        sqe_cnt <= sqe_cnt - 4'h1;
    end
  end

  // receive pins move on the falling edge so the mac sees stable data
  always_ff @(negedge mii_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mii_rx <= '0;
      mii_col <= 1'b0;
      rx_clk_from_line <= 1'b0;
    end
    else if (mce)
    begin
      mii_rx.er <= 1'b0;
      unique case (line_rx.sym)
        pmc_pkg::SYM_JK:
        begin
          mii_rx.crs <= 1'b1;
          mii_rx.dv <= 1'b1;
          mii_rx.d <= line_rx.d;
        end
        pmc_pkg::SYM_PRE:
        begin
          mii_rx.crs <= 1'b1;
          mii_rx.d <= 4'h0;
        end
        pmc_pkg::SYM_SFD:
        begin
          mii_rx.crs <= 1'b1;
          mii_rx.dv <= 1'b1;
          mii_rx.d <= line_rx.d;
        end
        pmc_pkg::SYM_DATA:
          mii_rx.d <= (mred && !line_lock) ? 4'h0 : line_rx.d;
        pmc_pkg::SYM_ERR:
        begin
          mii_rx.er <= 1'b1;
          mii_rx.d <= `PMC_RX_ERR_NIBBLE;
        end
        pmc_pkg::SYM_TR, pmc_pkg::SYM_EOF:
        begin
          mii_rx <= '0;
        end
        pmc_pkg::SYM_IDLE:
        begin
          mii_rx.er <= mii_rx.crs && m100;
          mii_rx.crs <= 1'b0;
          mii_rx.dv <= 1'b0;
          mii_rx.d <= 4'h0;
        end
        default: mii_rx <= '0;
      endcase
      // registered on this edge from the carrier of the edge before, so it lags a carrier rise by a full cycle
      mii_col <= jab10 || sqe_cnt != 4'h0 ||
                 (!mfull && tx_q.en && mii_rx.crs);
      rx_clk_from_line <= m100 ? (mlink || man) : mii_rx.crs;
    end
  end
endmodule : pmc_phy

// File: inc/pmc_params.svh
// constants for the transceiver control block: offsets, fields, timing
// assumes a 50 MHz core clock and clause 22 management framing
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PMC_REG_CTRL 5'h00
`define PMC_REG_ADV 5'h04
`define PMC_REG_LPA 5'h05
`define PMC_REG_INT 5'h1B
`define PMC_REG_PCTL 5'h1F
// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define PMC_CTRL_SPD 13
`define PMC_CTRL_ANEN 12
`define PMC_CTRL_RESTART 9
`define PMC_CTRL_DUP 8
`define PMC_PCTL_POL 9
`define PMC_ADV_RESET 16'h0001
`define PMC_ABIL_100FD 16'h0100
`define PMC_ABIL_100HD 16'h0080
`define PMC_ABIL_10FD 16'h0040
`define PMC_ABIL_10HD 16'h0020
`define PMC_LCW_ACK_MASK 16'hBFFF
`define PMC_INT_LINK_UP 0
`define PMC_INT_LINK_DOWN 2
`define PMC_INT_PAGE_RX 5
`define PMC_RX_ERR_NIBBLE 4'hE
// ----------------------------------------------------------------------
// timing and counts
// ----------------------------------------------------------------------
`define PMC_CORE_HZ 50000000
`define PMC_JAB_MS 20
`define PMC_UNJAB_MS 250
`define PMC_SQE_CYCLES 4'h4
`define PMC_LCW_REPEAT 2'h3
`define PMC_MDIO_PRE_ONES 6'h20
`define PMC_MDIO_HDR_LAST 4'hC
`define PMC_MDIO_DATA_LAST 5'h11
`define PMC_STRAP_WAIT 2'h3
`endif

// File: inc/pmc_pkg.sv
// types shared by the transceiver control block
// assumes nothing beyond the params header
package pmc_pkg;
  typedef enum logic [2:0] {
    SYM_IDLE, SYM_JK, SYM_DATA, SYM_TR, SYM_ERR, SYM_PRE, SYM_SFD, SYM_EOF
  } pmc_sym_type;
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } pmc_mii_tx_type;
  typedef struct packed {
    logic crs;
    logic dv;
    logic er;
    logic [3:0] d;
  } pmc_mii_rx_type;
  typedef struct packed {
    pmc_sym_type sym;
    logic [3:0] d;
  } pmc_line_rx_type;
  typedef struct packed {
    logic active;
    logic halt;
    logic [3:0] d;
  } pmc_line_tx_type;
  typedef enum {AN_OFF, AN_SEND, AN_ACK, AN_DONE} pmc_an_type;
  typedef enum {MD_IDLE, MD_HDR, MD_DATA} pmc_md_type;
endpackage : pmc_pkg

// File: sim/pmc_phy_assertions.sv
// checker for the transceiver control block, bound to its ports
// assumes the mode outputs settle before traffic is applied
// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
module pmc_phy_assertions #(
  parameter int JAB_CYCLES = 50
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mii_clk,
  input wire pmc_pkg::pmc_mii_tx_type mii_tx,
  input wire pmc_pkg::pmc_mii_rx_type mii_rx,
  input wire logic mii_col,
  input wire pmc_pkg::pmc_line_rx_type line_rx,
  input wire pmc_pkg::pmc_line_tx_type line_tx,
  input wire logic mode_100,
  input wire logic mode_full
);
  int unsigned jab_cnt;
  // margin covers the crossing of enable in and collision out
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      jab_cnt <= 0;
    else if (mii_tx.en && !mode_100)
      jab_cnt <= jab_cnt + 1;
    else
      jab_cnt <= 0;
  end
  sequence s_lost_carrier;
    mode_100 && mii_rx.crs ##1 line_rx.sym == pmc_pkg::SYM_IDLE;
  endsequence
  sequence s_one_err;
    !mii_rx.crs && mii_rx.er ##1 !mii_rx.er;
  endsequence
  AST_RX_START:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      line_rx.sym == pmc_pkg::SYM_JK |-> mii_rx.crs && mii_rx.dv)
    else $error("start pair without carrier and valid");
  AST_RX_PRE:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      line_rx.sym == pmc_pkg::SYM_PRE |-> mii_rx.crs && !mii_rx.dv)
    else $error("preamble not dropped");
  AST_RX_ERR:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      line_rx.sym == pmc_pkg::SYM_ERR |-> mii_rx.er && mii_rx.d == 4'hE)
    else $error("error symbol not flagged");
  AST_RX_END:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      line_rx.sym == pmc_pkg::SYM_TR |-> !mii_rx.crs && !mii_rx.dv)
    else $error("end pair left carrier up");
  AST_RX_LOST:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      s_lost_carrier |-> s_one_err)
    else $error("idle abort error not one cycle");
  AST_TX_FOLLOW:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      mii_tx.en && !mii_tx.er && mode_100
      |=> line_tx.active && line_tx.d == $past(mii_tx.d))
    else $error("transmit nibble not passed");
  AST_TX_HALT:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      mii_tx.en && mii_tx.er && mode_100 |=> line_tx.halt)
    else $error("transmit error sent no halt");
  AST_COL:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      mii_tx.en && mii_rx.crs && !mode_full |-> ##[0:2] mii_col)
    else $error("no collision in half duplex");
  AST_SQE:
    assert property (@(posedge mii_clk) disable iff (!rst_n)
      !mode_100 && $fell(mii_tx.en) |-> ##[0:2] mii_col)
    else $error("no self test pulse");
  AST_JABBER:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      jab_cnt > JAB_CYCLES + 40 |-> mii_col)
    else $error("long transmit not locked out");
endmodule : pmc_phy_assertions
bind pmc_phy pmc_phy_assertions #(.JAB_CYCLES(JAB_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .mii_clk(mii_clk),
  .mii_tx(mii_tx), .mii_rx(mii_rx), .mii_col(mii_col),
  .line_rx(line_rx), .line_tx(line_tx), .mode_100(mode_100),
  .mode_full(mode_full));

// File: sim/pmc_mac_model.sv
// mac side model: sends one frame of nibbles per go pulse
// assumes the link clock comes from the transceiver side
// ----------------------------------------------------------------
// frame sender
// ----------------------------------------------------------------
module pmc_mac_model (
  input wire logic mii_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [7:0] er_at,
  output pmc_pkg::pmc_mii_tx_type mii_tx
);
  logic [7:0] left;
  always_ff @(posedge mii_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mii_tx <= '0;
      left <= 8'h00;
    end
    else if (go && !mii_tx.en)
    begin
      mii_tx <= {1'b1, er_at == len, 4'h5};
      left <= len - 8'h01;
    end
    else if (left != 8'h00)
    begin
      mii_tx <= {1'b1, er_at == left, left[3:0]};
      left <= left - 8'h01;
    end
    else
      mii_tx <= {2'b00, ~mii_tx.d}; // stale nibble flipped, never held
  end
endmodule : pmc_mac_model

// File: sim/testbench.sv
// self-checking bench for the transceiver control block
// assumes straps give address 1, 100 half, negotiation off
`include "pmc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, mii_clk = 0, rst_n = 0, mdc = 0, host_md = 1;
  logic link_up = 0, lcw_valid = 0, mac_go = 0, drove = 0, nlp = 0, idle = 0;
  logic [15:0] lcw_word = 16'h0000, rd, flp_word;
  logic [7:0] mac_len = 8'h00, mac_er = 8'h00;
  logic [4:0] straps = 5'h01;
  logic an_en = 0, spd = 1, full = 0;
  pmc_pkg::pmc_line_rx_type line_rx = '0;
  pmc_pkg::pmc_mii_tx_type mac_tx;
  pmc_pkg::pmc_mii_rx_type mii_rx;
  pmc_pkg::pmc_line_tx_type line_tx;
  logic mii_col, flp_send, mode_100, mode_full, md_out, md_oe_n, irq, rxsrc;
  wire logic mdio_in = md_oe_n ? host_md : md_out;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  pmc_phy #(.JAB_CYCLES(50), .UNJAB_CYCLES(200)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .mii_clk(mii_clk),
    .mii_tx(mac_tx), .mii_rx(mii_rx), .mii_col(mii_col),
    .line_rx(line_rx), .line_lock(1'b1), .line_tx(line_tx),
    .rx_clk_from_line(rxsrc), .link_up(link_up), .nlp_seen(nlp),
    .idle100_seen(idle), .lcw_valid(lcw_valid), .lcw_word(lcw_word),
    .flp_send(flp_send), .flp_word(flp_word), .mode_100(mode_100),
    .mode_full(mode_full), .address_straps(straps), .strap_an_en(an_en),
    .strap_speed100(spd), .strap_full(full), .strap_reduced(1'b0),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(md_out),
    .mdio_oe_n(md_oe_n), .mgmt_irq_out(irq));
  pmc_mac_model mac_m (.mii_clk(mii_clk), .rst_n(rst_n), .go(mac_go),
    .len(mac_len), .er_at(mac_er), .mii_tx(mac_tx));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    #3;
    forever #62.5 mii_clk = ~mii_clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic mdio(input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, input logic [4:0] pa = 5'h01);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    drove = 1'b0;
    for (int i = 63; i >= 0; i--)
    begin
      host_md <= (op == 2'b10 && i < 18) ? 1'b1 : fr[i];
      mdc <= 1'b0;
      repeat (6) @(posedge core_clk);
      if (i < 16)
        rd = {rd[14:0], mdio_in};
      drove |= !md_oe_n;
      mdc <= 1'b1;
      repeat (6) @(posedge core_clk);
    end
    mdc <= 1'b0;
    host_md <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : mdio
  task automatic rx(input pmc_pkg::pmc_sym_type s, input logic [3:0] d,
                    input logic [6:0] e);
    line_rx <= {s, d};
    @(posedge mii_clk);
    if (s == pmc_pkg::SYM_DATA || s == pmc_pkg::SYM_ERR)
      chk({9'h000, mii_rx}, {9'h000, e});
    else
      chk({9'h000, mii_rx[6:4], 4'h0}, {9'h000, e});
  endtask : rx
  task automatic mac(input logic [7:0] len, input logic [7:0] er_at);
    @(posedge mii_clk);
    mac_len <= len;
    mac_er <= er_at;
    mac_go <= 1'b1;
    @(posedge mii_clk);
    mac_go <= 1'b0;
  endtask : mac
  task automatic mac_idle;
    for (int n = 0; n == 0 || (n < 100 && mac_tx.en === 1'b1); n++)
      @(posedge mii_clk);
  endtask : mac_idle
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk({15'h0, irq}, 16'h0001);
    mdio(2'b01, `PMC_REG_PCTL, 16'h0200);
    chk({15'h0, irq}, 16'h0000);
    mdio(2'b01, `PMC_REG_INT, 16'h0100);
    link_up <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk({15'h0, irq}, 16'h0001);
    mdio(2'b10, `PMC_REG_INT, 16'h0000);
    chk(rd, 16'h0101);
    chk({15'h0, irq}, 16'h0000);
    mdio(2'b10, `PMC_REG_INT, 16'h0000, 5'h02);
    chk({15'h0, drove}, 16'h0000);
    mdio(2'b10, `PMC_REG_INT, 16'h0000);
    chk(rd, 16'h0100);
    $display("management test done");
    @(posedge mii_clk);
    rx(pmc_pkg::SYM_JK, 4'h5, 7'h60);
    rx(pmc_pkg::SYM_DATA, 4'hA, 7'h6A);
    rx(pmc_pkg::SYM_ERR, 4'h0, 7'h7E);
    rx(pmc_pkg::SYM_TR, 4'h0, 7'h00);
    rx(pmc_pkg::SYM_JK, 4'h5, 7'h60);
    rx(pmc_pkg::SYM_IDLE, 4'h0, 7'h10);
    rx(pmc_pkg::SYM_IDLE, 4'h0, 7'h00);
    mac(8'd6, 8'd3);
    rx(pmc_pkg::SYM_JK, 4'h5, 7'h60);
    rx(pmc_pkg::SYM_DATA, 4'h1, 7'h61);
    chk({15'h0, mii_col}, 16'h0001);
    chk({15'h0, rxsrc}, 16'h0001);
    rx(pmc_pkg::SYM_TR, 4'h0, 7'h00);
    mac_idle();
    $display("100 half test done");
    mdio(2'b01, `PMC_REG_ADV, 16'h01E1);
    mdio(2'b01, `PMC_REG_CTRL, 16'h1200);
    chk({15'h0, flp_send}, 16'h0001);
    chk(flp_word, 16'h01E1);
    for (int k = 0; k < 6; k++)
    begin
      lcw_word <= (k < 3) ? 16'h00C1 : 16'h40C1;
      lcw_valid <= 1'b1;
      @(posedge core_clk);
      lcw_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    chk({14'h0, mode_100, mode_full}, 16'h0002);
    mdio(2'b10, `PMC_REG_LPA, 16'h0000);
    chk(rd & 16'hBFFF, 16'h00C1);
    for (int p = 0; p < 2; p++)
    begin
      {idle, nlp} <= {p[0], 1'b1};
      mdio(2'b01, `PMC_REG_CTRL, 16'h1200);
      chk({14'h0, mode_100, mode_full}, {14'h0, p[0], 1'b0});
    end
    $display("negotiation test done");
    mdio(2'b01, `PMC_REG_CTRL, 16'h0000);
    chk({14'h0, mode_100, mode_full}, 16'h0000);
    @(posedge mii_clk);
    rx(pmc_pkg::SYM_PRE, 4'h5, 7'h40);
    rx(pmc_pkg::SYM_SFD, 4'h5, 7'h60);
    rx(pmc_pkg::SYM_DATA, 4'hD, 7'h6D);
    rx(pmc_pkg::SYM_EOF, 4'h0, 7'h00);
    mac(8'd3, 8'd0);
    mac_idle();
    @(posedge mii_clk);
    chk({15'h0, mii_col}, 16'h0001);
    repeat (8) @(posedge mii_clk);
    mac(8'd20, 8'd0);
    repeat (16) @(posedge mii_clk);
    chk({14'h0, mii_col, line_tx.active}, 16'h0002);
    mac_idle();
    repeat (8) @(posedge mii_clk);
    chk({15'h0, mii_col}, 16'h0001);
    repeat (30) @(posedge mii_clk);
    chk({15'h0, mii_col}, 16'h0000);
    $display("10 half test done");
    print_verdict();
  end
endmodule : testbench
